// >>> common/temp_monitor_regs.vh
`ifndef TEMP_MONITOR_REGS_VH
`define TEMP_MONITOR_REGS_VH
`define ADDR_LOCAL_VALUE   8'h00
`define ADDR_REMOTE_VALUE  8'h04
`define ADDR_STATUS        8'h08
`define ADDR_CONFIG        8'h0c
`define ADDR_RATE          8'h10
`define ADDR_LOCAL_HIGH    8'h14
`define ADDR_LOCAL_LOW     8'h18
`define ADDR_REMOTE_HIGH   8'h1c
`define ADDR_REMOTE_LOW    8'h20
`define ADDR_ONE_SHOT      8'h24
`define ADDR_REVISION      8'h28
`define ADDR_IRQ_MASK      8'h2c
`define BIT_BUSY           7
`define BIT_LOCAL_HIGH     6
`define BIT_LOCAL_LOW      5
`define BIT_REMOTE_HIGH    4
`define BIT_REMOTE_LOW     3
`define BIT_OPEN           2
`define BIT_CFG_MASK       7
`define BIT_CFG_STOP       6
`define RST_VALUE          8'h80
`define RST_CONFIG         8'h00
`define RST_RATE           8'h02
`define RST_HIGH_LIMIT     8'h7f
`define RST_LOW_LIMIT      8'hc9
`define RST_IRQ_MASK       8'h00
`define FLAG_MASK          8'h7c
`define AVG_COUNT          16
`define AVG_SHIFT          4
`define RAW_PERIOD_CYCLES  64
`endif

// >>> verilog/temp_averager.v
`timescale 1ns/1ns
`include "temp_monitor_regs.vh"
module temp_averager #(
  parameter COUNT = `AVG_COUNT,
  parameter SHIFT = `AVG_SHIFT
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       clear,
  input  wire       sample_valid,
  input  wire [7:0] sample,
  output reg  [7:0] result,
  output reg        result_valid
);
  reg [11:0] sum;
  reg [4:0]  count;
  wire [11:0] next_sum = sum + {{4{sample[7]}}, sample};
  wire [11:0] mean     = $signed(next_sum) >>> SHIFT;

  // negative or oversized means clamp into the measurable range
  function [7:0] clamp;
    input [11:0] v;
    begin
      if (v[11])
        clamp = 8'h00;
      else if (v[10:7] != 4'h0)
        clamp = 8'h7f;
      else
        clamp = v[7:0];
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum          <= 12'h000;
      count        <= 5'h00;
      result       <= 8'h00;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (clear) begin
        sum   <= 12'h000;
        count <= 5'h00;
      end else if (sample_valid) begin
        if (count == COUNT - 1) begin
          result       <= clamp(mean);
          result_valid <= 1'b1;
          sum          <= 12'h000;
          count        <= 5'h00;
        end else begin
          sum   <= next_sum;
          count <= count + 5'h01;
        end
      end
    end
  end
endmodule // temp_averager

// >>> verilog/dual_temp_monitor_core.v
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "temp_monitor_regs.vh"
module dual_temp_monitor_core #(
  parameter [3:0] PART_CODE    = 4'h5, // arbitrary identification value
  parameter [3:0] DIE_REVISION = 4'h1, // arbitrary
  parameter       RAW_PERIOD   = `RAW_PERIOD_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        sleep_select_n,
  input  wire [7:0]  local_raw,
  input  wire [7:0]  remote_raw,
  input  wire        remote_open,
  output wire        alert_n_o,
  output wire        alert_n_oe,
  output wire        irq
);
  reg  [7:0]  local_value;
  reg  [7:0]  remote_value;
  reg  [7:0]  config_reg;
  reg  [7:0]  rate;
  reg  [7:0]  local_high;
  reg  [7:0]  local_low;
  reg  [7:0]  remote_high;
  reg  [7:0]  remote_low;
  reg  [7:0]  irq_mask;
  reg  [7:0]  flags;
  reg  [7:0]  irq_status;
  reg         sleep_select_n_meta;
  reg         sleep_select_n_sync;
  reg         open_meta;
  reg         open_sync;
  reg         channel;
  reg  [1:0]  boot_state;
  reg  [15:0] raw_timer;
  reg  [7:0]  rate_timer;
  reg         one_shot;
  reg         have_local;
  reg         have_remote;
  reg         compare_en;

  localparam BOOT_WAIT = 2'b00;
  localparam BOOT_RUN  = 2'b01;
  localparam BOOT_DONE = 2'b10;

  wire wr   = psel && penable && pwrite;
  wire rd   = psel && penable && !pwrite;
  wire standby  = config_reg[`BIT_CFG_STOP] || !sleep_select_n_sync;
  wire running  = (!standby || one_shot) && boot_state != BOOT_WAIT;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  function [7:0] period_of;
    input [2:0] code;
    begin
      period_of = 8'h80 >> code;
    end
  endfunction

  function signed_lt;
    input [7:0] a;
    input [7:0] b;
    begin
      signed_lt = $signed(a) < $signed(b);
    end
  endfunction

  // pin inputs pass two flip-flops before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_select_n_meta <= 1'b1;
      sleep_select_n_sync <= 1'b1;
      open_meta <= 1'b0;
      open_sync <= 1'b0;
    end else begin
      sleep_select_n_meta <= sleep_select_n;
      sleep_select_n_sync <= sleep_select_n_meta;
      open_meta <= remote_open;
      open_sync <= open_meta;
    end
  end

  // the strap is read once the synchronised pin has settled after release
  reg [1:0] settle;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_state <= BOOT_WAIT;
      settle     <= 2'b00;
      compare_en <= 1'b0;
    end else begin
      case (boot_state)
        BOOT_WAIT: begin
          settle <= settle + 2'b01;
          if (settle == 2'b11) begin
            if (!sleep_select_n_sync) begin
              boot_state <= BOOT_DONE;
              compare_en <= 1'b1;
            end else begin
              boot_state <= BOOT_RUN;
            end
          end
        end
        BOOT_RUN: begin
          if (have_local && have_remote) begin
            boot_state <= BOOT_DONE;
            compare_en <= 1'b1;
          end
        end
        BOOT_DONE: boot_state <= BOOT_DONE;
        default:   boot_state <= BOOT_WAIT;
      endcase
    end
  end

  // raw sample strobe; each raw cycle divides down by the rate code
  wire raw_tick = running && raw_timer == RAW_PERIOD - 1 && rate_timer == 8'h00;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_timer  <= 16'h0000;
      rate_timer <= 8'h00;
    end else if (!running) begin
      raw_timer  <= 16'h0000;
      rate_timer <= 8'h00;
    end else if (raw_timer == RAW_PERIOD - 1) begin
      raw_timer  <= 16'h0000;
      rate_timer <= (rate_timer == 8'h00) ? period_of(rate[2:0]) - 8'h01 : rate_timer - 8'h01;
    end else begin
      raw_timer <= raw_timer + 16'h0001;
    end
  end

  wire [7:0] avg_result;
  wire       avg_valid;
  temp_averager u_avg (
    .pclk         (pclk),
    .presetn      (presetn),
    .clear        (!running),
    .sample_valid (raw_tick),
    .sample       (channel ? remote_raw : local_raw),
    .result       (avg_result),
    .result_valid (avg_valid)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_value  <= `RST_VALUE;
      remote_value <= `RST_VALUE;
      channel      <= 1'b0;
      have_local   <= 1'b0;
      have_remote  <= 1'b0;
      one_shot     <= 1'b0;
    end else begin
      if (avg_valid) begin
        channel <= ~channel;
        if (channel) begin
          remote_value <= avg_result;
          have_remote  <= 1'b1;
          one_shot     <= 1'b0;
        end else begin
          local_value <= avg_result;
          have_local  <= 1'b1;
        end
      end
      // a single conversion covers both channels, local first; a request during one is ignored
      if (wr && paddr == `ADDR_ONE_SHOT && standby && !one_shot) begin
        one_shot <= 1'b1;
        channel  <= 1'b0;
      end
    end
  end

  wire [7:0] cond;
  assign cond[7]                = 1'b0;
  assign cond[`BIT_LOCAL_HIGH]  = compare_en && signed_lt(local_high, local_value);
  assign cond[`BIT_LOCAL_LOW]   = compare_en && signed_lt(local_value, local_low);
  assign cond[`BIT_REMOTE_HIGH] = compare_en && signed_lt(remote_high, remote_value);
  assign cond[`BIT_REMOTE_LOW]  = compare_en && signed_lt(remote_value, remote_low);
  assign cond[`BIT_OPEN]        = compare_en && open_sync;
  assign cond[1:0]              = 2'b00;

  wire status_rd = rd && paddr == `ADDR_STATUS;
  wire [7:0] flag_events = cond & ~flags;

  // a live condition keeps its flag set through a status read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      flags <= 8'h00;
    else if (status_rd)
      flags <= cond;
    else
      flags <= flags | cond;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg  <= `RST_CONFIG;
      rate        <= `RST_RATE;
      local_high  <= `RST_HIGH_LIMIT;
      local_low   <= `RST_LOW_LIMIT;
      remote_high <= `RST_HIGH_LIMIT;
      remote_low  <= `RST_LOW_LIMIT;
      irq_mask    <= `RST_IRQ_MASK;
    end else if (wr) begin
      case (paddr)
        `ADDR_CONFIG:      config_reg  <= pwdata[7:0] & 8'hc0;
        `ADDR_RATE:        rate        <= pwdata[7:0] & 8'h07;
        `ADDR_LOCAL_HIGH:  local_high  <= pwdata[7:0];
        `ADDR_LOCAL_LOW:   local_low   <= pwdata[7:0];
        `ADDR_REMOTE_HIGH: remote_high <= pwdata[7:0];
        `ADDR_REMOTE_LOW:  remote_low  <= pwdata[7:0];
        `ADDR_IRQ_MASK:    irq_mask    <= pwdata[7:0] & `FLAG_MASK;
        default:           irq_mask    <= irq_mask;
      endcase
    end
  end

  // sticky event bits, write one to clear; a new event wins over the clear
  wire [7:0] w1c = (wr && paddr == `ADDR_STATUS) ? pwdata[7:0] : 8'h00;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_status <= 8'h00;
    else
      irq_status <= ((irq_status & ~w1c) | flag_events) & `FLAG_MASK;
  end

  assign irq = |(irq_status & irq_mask);

  // alert is a plain level of the latched flags so the mask hides pending ones too
  assign alert_n_o  = 1'b0;
  assign alert_n_oe = (|(flags & `FLAG_MASK)) && !config_reg[`BIT_CFG_MASK];

  wire busy = running;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        `ADDR_LOCAL_VALUE:  prdata <= {24'h000000, local_value};
        `ADDR_REMOTE_VALUE: prdata <= {24'h000000, remote_value};
        `ADDR_STATUS:       prdata <= {24'h000000, busy, flags[6:0] & 7'h7c};
        `ADDR_CONFIG:       prdata <= {24'h000000, config_reg};
        `ADDR_RATE:         prdata <= {24'h000000, rate};
        `ADDR_LOCAL_HIGH:   prdata <= {24'h000000, local_high};
        `ADDR_LOCAL_LOW:    prdata <= {24'h000000, local_low};
        `ADDR_REMOTE_HIGH:  prdata <= {24'h000000, remote_high};
        `ADDR_REMOTE_LOW:   prdata <= {24'h000000, remote_low};
        `ADDR_REVISION:     prdata <= {24'h000000, PART_CODE, DIE_REVISION};
        `ADDR_IRQ_MASK:     prdata <= {24'h000000, irq_mask};
        default:            prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // dual_temp_monitor_core

// >>> tb/temp_monitor_checker_monitor.sv
`timescale 1ns/1ns
module temp_monitor_checker #(
  parameter [3:0] PART_CODE    = 4'h5,
  parameter [3:0] DIE_REVISION = 4'h1
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        alert_n_o,
  input wire        alert_n_oe,
  input wire        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_setup(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence wr_done(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  // the bench leaves exactly one idle cycle between two consecutive apb task calls
  property limit_readback_p;
    wr_done(8'h14) ##1 !psel ##1 rd_setup(8'h14) |=> prdata[7:0] == $past(pwdata[7:0], 3);
  endproperty
  ready_now_a: assert property (psel && penable |-> pready) else $error("no ready");
  no_error_a: assert property (psel && penable |-> !pslverr) else $error("slave error");
  alert_drive_a: assert property (alert_n_oe |-> !alert_n_o) else $error("alert drives high");
  upper_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
  reset_quiet_a: assert property ($rose(presetn) |-> !irq && !alert_n_oe) else $error("active at reset");
  revision_read_a: assert property (rd_setup(8'h28) |=> prdata == {24'h0, PART_CODE, DIE_REVISION})
    else $error("revision");
  unmapped_read_a: assert property (rd_setup(8'h30) |=> prdata == 32'h0) else $error("unmapped read");
  mask_write_a: assert property (wr_done(8'h0c) ##0 pwdata[7] |=> !alert_n_oe) else $error("mask ignored");
  irq_mask_a: assert property (wr_done(8'h2c) ##0 pwdata[7:0] == 8'h00 |=> !irq) else $error("irq unmasked");
  limit_readback_a: assert property (limit_readback_p) else $error("limit readback");
endmodule // temp_monitor_checker
bind dual_temp_monitor_core temp_monitor_checker #(.PART_CODE(PART_CODE), .DIE_REVISION(DIE_REVISION)) u_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe), .irq(irq));

// >>> tb/sensor_model.sv
`timescale 1ns/1ns
module sensor_model (
  input  wire logic       pclk,
  input  wire logic [7:0] local_temp,
  input  wire logic [7:0] remote_temp,
  input  wire logic       open_cmd,
  input  wire logic       alert_n_o,
  input  wire logic       alert_n_oe,
  output logic      [7:0] local_raw,
  output logic      [7:0] remote_raw,
  output logic            remote_open,
  output wire logic       alert_wire
);
  logic [2:0] ph = 3'h0;
  // +1/-1 noise that flips every four cycles: only a true average recovers the temperature
  wire [7:0] jit = ph[2] ? 8'hff : 8'h01;
  initial begin
    local_raw = 8'h00;
    remote_raw = 8'h00;
    remote_open = 1'b0;
  end
  always @(posedge pclk) begin
    ph <= ph + 3'h1;
    local_raw <= local_temp + jit;
    remote_raw <= remote_temp + jit;
    remote_open <= open_cmd;
  end
  // pull-up on the open-drain alert line
  assign alert_wire = alert_n_oe ? alert_n_o : 1'b1;
endmodule // sensor_model

// >>> tb/test_dual_temp_monitor_core.sv
`timescale 1ns/1ns
module test_dual_temp_monitor_core;
  typedef struct {logic [7:0] a; logic [31:0] e;} row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_select_n = 0, open_cmd = 0;
  logic [7:0]  paddr = 8'h00, local_temp = 8'h19, remote_temp = 8'h64;
  logic [31:0] pwdata = 32'h0, rd;
  wire  [31:0] prdata;
  wire  [7:0]  local_raw, remote_raw;
  wire         pready, pslverr, alert_n_o, alert_n_oe, irq, remote_open, alert_wire;
  int          num_errors = 0, comparisons = 0;
  row_t rows[12] = '{'{8'h00, 32'h80}, '{8'h04, 32'h80}, '{8'h08, 32'h28}, '{8'h0c, 32'h00},
                     '{8'h10, 32'h02}, '{8'h14, 32'h7f}, '{8'h18, 32'hc9}, '{8'h1c, 32'h7f},
                     '{8'h20, 32'hc9}, '{8'h28, 32'h51}, '{8'h2c, 32'h00}, '{8'h30, 32'h00}};
  always #20 pclk = ~pclk;
  dual_temp_monitor_core #(.PART_CODE(4'h5), .DIE_REVISION(4'h1), .RAW_PERIOD(4)) u_dual_temp_monitor_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_select_n(sleep_select_n),
    .local_raw(local_raw), .remote_raw(remote_raw), .remote_open(remote_open),
    .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe), .irq(irq));
  sensor_model u_sensor_model (
    .pclk(pclk), .local_temp(local_temp), .remote_temp(remote_temp), .open_cmd(open_cmd),
    .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe), .local_raw(local_raw), .remote_raw(remote_raw),
    .remote_open(remote_open), .alert_wire(alert_wire));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(32'(pready), 32'h1);
    chk(32'(pslverr), 32'h0);
    if (n >= 50) wrap_up;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd[7:0] & m) !== e && n < 400);
    chk({24'h0, rd[7:0] & m}, {24'h0, e});
    // a poll that ran out has already counted its mismatch
    if ((rd[7:0] & m) !== e) wrap_up;
  endtask
  task pin(input logic [31:0] e);
    @(negedge pclk);
    chk({31'h0, alert_wire}, e);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    pin(32'h0);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
    end
    $display("test reset_values done");
    apb(1'b1, 8'h0c, 32'h80);
    pin(32'h1);
    apb(1'b1, 8'h0c, 32'h00);
    pin(32'h0);
    apb(1'b1, 8'h18, 32'h80);
    apb(1'b1, 8'h20, 32'h80);
    apb(1'b0, 8'h08, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h7c, 32'h0);
    pin(32'h1);
    apb(1'b1, 8'h2c, 32'h28);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h2c, 32'h00);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h2c, 32'h28);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h08, 32'h28);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h10, 32'h07);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h07);
    $display("test standby_alert done");
    sleep_select_n <= 1'b1;
    poll(8'h00, 8'hff, 8'h19);
    poll(8'h04, 8'hff, 8'h64);
    poll(8'h08, 8'h80, 8'h80);
    apb(1'b1, 8'h14, 32'h14);
    apb(1'b0, 8'h14, 32'h0);
    poll(8'h08, 8'h40, 8'h40);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h40, 32'h40);
    pin(32'h0);
    apb(1'b1, 8'h14, 32'h7f);
    apb(1'b0, 8'h08, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h7c, 32'h0);
    $display("test limits done");
    local_temp <= 8'hf6;
    poll(8'h00, 8'hff, 8'h00);
    local_temp <= 8'h19;
    open_cmd <= 1'b1;
    poll(8'h08, 8'h04, 8'h04);
    pin(32'h0);
    @(posedge pclk);
    open_cmd <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    poll(8'h08, 8'h04, 8'h00);
    $display("test clamp_open done");
    // second reset, now powered up running: no low flags before real results
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // the default rate would keep the first results far beyond the poll limit
    apb(1'b1, 8'h10, 32'h07);
    poll(8'h04, 8'hff, 8'h64);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h7c, 32'h0);
    pin(32'h1);
    apb(1'b1, 8'h0c, 32'h40);
    local_temp <= 8'h3c;
    repeat (300) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h19);
    remote_temp <= 8'h50;
    apb(1'b1, 8'h24, 32'h0);
    poll(8'h04, 8'hff, 8'h50);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h3c);
    poll(8'h08, 8'h80, 8'h00);
    $display("test run_stop done");
    wrap_up;
  end
endmodule // test_dual_temp_monitor_core
